//--- shared/comm_supervision_regs.svh
// constants of the communication supervision block
// What this block does
// [R1] The silent-window length is a millisecond setting from 0 up to 60000.
// [R2] A full window with no correctly completed transfer raises the communication timeout fault.
// [R3] A window setting of zero turns supervision off, and zero is the reset value.
// [R4] Reaction code 0 keeps the operating point and code 1, the default, enters the fault state at once.
// [R5] Codes 2 and 3 issue disable-voltage or quick-stop and then go to switch-on-disabled.
// [R6] Codes 4 and 5 issue disable-operation or quick-stop and enter the error state once the drive rests.
// [R7] Codes 2 to 5 act only while the control-source selector equals 1.
// [R8] Only the client opens exchanges and the server never originates traffic.
// [R9] Connections are accepted on server port 502 only.
// [R10] At most one request is outstanding, and the client waits for each response.
// [R11] Address assignment is static when the option is 0, the default, and DHCP when it is 1.
// [R12] The window timer restarts on every good transfer and on every change of the window setting.
`ifndef COMM_SUPERVISION_REGS_SVH
`define COMM_SUPERVISION_REGS_SVH
`define CLOCK_HZ 40000000
`define MS_PER_S 1000
`define CYCLES_PER_MS (`CLOCK_HZ / `MS_PER_S)
`define WINDOW_MAX_MS 16'hEA60
`define WINDOW_RESET_MS 16'h0000
`define REACTION_RESET 3'h1
`define CONTROL_VIA_STATE_MACHINE 2'h1
`define MODBUS_PORT 16'h01F6
`define ADDR_STATIC 1'b0
`define ADDR_DHCP 1'b1
`endif

//--- shared/comm_supervision_pkg.sv
// types of the communication supervision block
package comm_supervision_pkg;
  typedef enum logic [2:0]
  {
    react_none = 3'h0,
    react_fault = 3'h1,
    react_stop = 3'h2,
    react_quick_stop = 3'h3,
    react_shutdown_fault = 3'h4,
    react_quick_fault = 3'h5
  } reaction_type;

  typedef enum logic [2:0]
  {
    st_idle = 3'h0,
    st_stopping = 3'h1,
    st_disabled = 3'h3,
    st_fault = 3'h2
  } react_state_type;

  typedef enum logic [1:0]
  {
    cmd_none = 2'h0,
    cmd_disable_voltage = 2'h1,
    cmd_quick_stop = 2'h2,
    cmd_disable_operation = 2'h3
  } drive_cmd_type;
endpackage : comm_supervision_pkg

//--- src/ms_tick.sv
// millisecond enable divider
`timescale 1ns/1ps
`include "comm_supervision_regs.svh"
module ms_tick #(
  parameter int unsigned CYCLES = `CYCLES_PER_MS
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // restart and tick
  input wire logic restart,
  output logic tick
);
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    count_d = count_q + 32'h1;
    if (restart)
    begin
      count_d = 32'h0;
    end
    else if (count_q == CYCLES - 1)
    begin
      count_d = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      tick <= tick_d;
    end
  end
endmodule : ms_tick

//--- src/sync2.sv
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sync2

//--- src/comm_supervision.sv
// communication timeout watchdog and bus error reaction
`timescale 1ns/1ps
`include "comm_supervision_regs.svh"
module comm_supervision #(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration
  input wire logic [15:0] window_ms,
  input wire logic [2:0] reaction_code,
  input wire logic [1:0] control_source,
  input wire logic addr_option,
  // transfer events from the server
  input wire logic request_valid,
  input wire logic [15:0] request_port,
  input wire logic request_good,
  input wire logic response_done,
  input wire logic bus_error,
  // drive feedback pin
  input wire logic drive_at_rest,
  // fault handling
  input wire logic fault_reset,
  // outputs
  output logic comm_timeout_fault,
  output logic fault_active,
  output logic switch_on_disabled,
  output logic [1:0] drive_cmd,
  output logic request_accept,
  output logic busy,
  output logic dhcp_enable
);
  // ----------------------------------------
  // input capture
  // ----------------------------------------
  logic at_rest_s;
  logic ms_en;
  logic restart;
  logic [15:0] window_q;
  logic [15:0] window_d;
  logic [15:0] window_eff;

  sync2 #(.WIDTH(1)) rest_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(drive_at_rest),
    .sync_out(at_rest_s)
  );

  // ----------------------------------------
  // request acceptance
  // ----------------------------------------
  logic busy_d;
  logic accept_d;
  logic good_xfer;

  always_comb
  begin
    accept_d = 1'b0;
    busy_d = busy;
    // only client requests open an exchange [R8]
    if (request_valid && !busy && request_port == `MODBUS_PORT) // [R9]
    begin
      accept_d = 1'b1;
      busy_d = 1'b1; // [R10]
    end
    else if (busy && response_done)
    begin
      busy_d = 1'b0; // [R10]
    end
  end

  assign good_xfer = busy && response_done && request_good;

  // ----------------------------------------
  // supervision window
  // ----------------------------------------
  logic [15:0] ms_count_q;
  logic [15:0] ms_count_d;
  logic timeout_d;

  assign window_eff = (window_ms > `WINDOW_MAX_MS) ? `WINDOW_MAX_MS : window_ms; // [R1]
  assign restart = good_xfer || (window_eff != window_q); // [R12]

  ms_tick #(.CYCLES(CYCLES_PER_MS)) ms_div (
    .clock(clock),
    .rst_n(rst_n),
    .restart(restart),
    .tick(ms_en)
  );

  always_comb
  begin
    window_d = window_eff;
    ms_count_d = ms_count_q;
    timeout_d = 1'b0;
    if (window_q == `WINDOW_RESET_MS)
    begin
      ms_count_d = 16'h0; // [R3]
    end
    else if (restart)
    begin
      ms_count_d = 16'h0; // [R12]
    end
    else if (ms_en)
    begin
      if (ms_count_q + 16'h1 >= window_q)
      begin
        ms_count_d = 16'h0;
        timeout_d = 1'b1; // [R2]
      end
      else
      begin
        ms_count_d = ms_count_q + 16'h1;
      end
    end
  end

  // ----------------------------------------
  // fault reaction
  // ----------------------------------------
  comm_supervision_pkg::react_state_type state_q;
  comm_supervision_pkg::react_state_type state_d;
  comm_supervision_pkg::drive_cmd_type cmd_d;
  logic timeout_flag_d;
  logic event_hit;
  logic via_sm;

  assign event_hit = timeout_d || bus_error;
  assign via_sm = control_source == `CONTROL_VIA_STATE_MACHINE;

  always_comb
  begin
    state_d = state_q;
    cmd_d = comm_supervision_pkg::drive_cmd_type'(drive_cmd);
    timeout_flag_d = comm_timeout_fault;
    if (fault_reset)
    begin
      timeout_flag_d = 1'b0;
    end
    if (timeout_d)
    begin
      timeout_flag_d = 1'b1; // [R2]
    end
    unique case (state_q)
      comm_supervision_pkg::st_idle:
      begin
        cmd_d = comm_supervision_pkg::cmd_none;
        if (event_hit)
        begin
          unique case (comm_supervision_pkg::reaction_type'(reaction_code))
            comm_supervision_pkg::react_none:
            begin
              state_d = comm_supervision_pkg::st_idle; // [R4]
            end
            comm_supervision_pkg::react_fault:
            begin
              state_d = comm_supervision_pkg::st_fault; // [R4]
            end
            comm_supervision_pkg::react_stop:
            begin
              if (via_sm) // [R7]
              begin
                cmd_d = comm_supervision_pkg::cmd_disable_voltage; // [R5]
                state_d = comm_supervision_pkg::st_disabled;
              end
            end
            comm_supervision_pkg::react_quick_stop:
            begin
              if (via_sm) // [R7]
              begin
                cmd_d = comm_supervision_pkg::cmd_quick_stop; // [R5]
                state_d = comm_supervision_pkg::st_disabled;
              end
            end
            comm_supervision_pkg::react_shutdown_fault:
            begin
              if (via_sm) // [R7]
              begin
                cmd_d = comm_supervision_pkg::cmd_disable_operation; // [R6]
                state_d = comm_supervision_pkg::st_stopping;
              end
            end
            comm_supervision_pkg::react_quick_fault:
            begin
              if (via_sm) // [R7]
              begin
                cmd_d = comm_supervision_pkg::cmd_quick_stop; // [R6]
                state_d = comm_supervision_pkg::st_stopping;
              end
            end
            default:
            begin
              state_d = comm_supervision_pkg::st_idle;
            end
          endcase
        end
      end
      comm_supervision_pkg::st_stopping:
      begin
        if (at_rest_s)
        begin
          state_d = comm_supervision_pkg::st_fault; // [R6]
        end
      end
      comm_supervision_pkg::st_disabled:
      begin
        if (fault_reset)
        begin
          state_d = comm_supervision_pkg::st_idle;
          cmd_d = comm_supervision_pkg::cmd_none;
        end
      end
      comm_supervision_pkg::st_fault:
      begin
        if (fault_reset)
        begin
          state_d = comm_supervision_pkg::st_idle;
          cmd_d = comm_supervision_pkg::cmd_none;
        end
      end
      default:
      begin
        state_d = comm_supervision_pkg::st_idle;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      window_q <= `WINDOW_RESET_MS;
      ms_count_q <= 16'h0;
      state_q <= comm_supervision_pkg::st_idle;
      drive_cmd <= 2'h0;
      comm_timeout_fault <= 1'b0;
      fault_active <= 1'b0;
      switch_on_disabled <= 1'b0;
      request_accept <= 1'b0;
      busy <= 1'b0;
      dhcp_enable <= `ADDR_STATIC;
    end
    else
    begin
      window_q <= window_d;
      ms_count_q <= ms_count_d;
      state_q <= state_d;
      drive_cmd <= cmd_d;
      comm_timeout_fault <= timeout_flag_d;
      fault_active <= state_d == comm_supervision_pkg::st_fault;
      switch_on_disabled <= state_d == comm_supervision_pkg::st_disabled;
      request_accept <= accept_d;
      busy <= busy_d;
      dhcp_enable <= addr_option == `ADDR_DHCP; // [R11]
    end
  end
endmodule : comm_supervision

//--- tb/comm_supervision_checker.sv
// port assertions of the supervision block
`timescale 1ns/1ps
module comm_supervision_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // watched ports
  input wire logic [2:0] reaction_code,
  input wire logic [1:0] control_source,
  input wire logic addr_option,
  input wire logic request_valid,
  input wire logic [15:0] request_port,
  input wire logic bus_error,
  input wire logic fault_reset,
  input wire logic fault_active,
  input wire logic switch_on_disabled,
  input wire logic [1:0] drive_cmd,
  input wire logic request_accept,
  input wire logic busy,
  input wire logic dhcp_enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic idle;
  logic hit;
  logic sm;
  logic port_ok;
  assign idle = !fault_active && !switch_on_disabled && drive_cmd == 2'h0;
  assign hit = bus_error && idle && !fault_reset;
  assign sm = control_source == 2'h1;
  assign port_ok = request_port == 16'h01F6;
  take_req_a: assert property (
    request_valid && !busy && port_ok |=> request_accept && busy) else $error("request dropped");
  wrong_port_a: assert property (
    request_valid && !port_ok |=> !request_accept) else $error("port not refused");
  busy_refuse_a: assert property (
    busy |=> !request_accept) else $error("taken while busy");
  no_origin_a: assert property (
    request_accept |-> $past(request_valid)) else $error("unrequested accept");
  dhcp_copy_a: assert property (
    1'b1 |=> dhcp_enable == $past(addr_option)) else $error("dhcp mismatch");
  fault_now_a: assert property (
    hit && reaction_code == 3'h1 |=> fault_active && drive_cmd == 2'h0) else $error("no fault");
  stop_cmd_a: assert property (
    hit && reaction_code == 3'h2 && sm |=> drive_cmd == 2'h1 && switch_on_disabled) else $error("no stop");
  gated_react_a: assert property (
    hit && reaction_code inside {[3'h2:3'h5]} && !sm |=> idle) else $error("ungated reaction");
  cover property (request_accept);
  cover property (hit && reaction_code == 3'h5);
  cover property ($rose(fault_active) && drive_cmd == 2'h3);
endmodule : comm_supervision_checker
bind comm_supervision comm_supervision_checker chk (
  .clock(clock),
  .rst_n(rst_n),
  .reaction_code(reaction_code),
  .control_source(control_source),
  .addr_option(addr_option),
  .request_valid(request_valid),
  .request_port(request_port),
  .bus_error(bus_error),
  .fault_reset(fault_reset),
  .fault_active(fault_active),
  .switch_on_disabled(switch_on_disabled),
  .drive_cmd(drive_cmd),
  .request_accept(request_accept),
  .busy(busy),
  .dhcp_enable(dhcp_enable)
);

//--- tb/modbus_client.sv
// client model at the server's transfer ports
`timescale 1ns/1ps
module modbus_client (
  // clock
  input wire logic clock,
  // server side
  input wire logic request_accept,
  output logic request_valid,
  output logic [15:0] request_port,
  output logic response_done,
  output logic request_good
);
  initial
  begin
    request_valid = 1'b0;
    request_port = 16'h0000;
    response_done = 1'b0;
    request_good = 1'b0;
  end
  // one request, accept flag back
  task automatic ask(input logic [15:0] p, output logic acc);
    request_valid <= 1'b1;
    request_port <= p;
    @(posedge clock);
    request_valid <= 1'b0;
    request_port <= ~p;
    #1;
    acc = request_accept;
    @(posedge clock);
  endtask : ask
  // completion of the outstanding request
  task automatic answer(input logic g);
    response_done <= 1'b1;
    request_good <= g;
    @(posedge clock);
    response_done <= 1'b0;
    request_good <= ~g;
    @(posedge clock);
  endtask : answer
endmodule : modbus_client

//--- tb/comm_supervision_tb.sv
// self-checking bench of the supervision block
`timescale 1ns/1ps
`include "comm_supervision_regs.svh"
module comm_supervision_tb;
  // ----
  // signals
  // ----
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] window_ms = 16'h0000;
  logic [2:0] reaction_code = 3'h0;
  logic [1:0] control_source = 2'h0;
  logic addr_option = 1'b0;
  logic bus_error = 1'b0;
  logic drive_at_rest = 1'b0;
  logic fault_reset = 1'b0;
  logic [15:0] request_port;
  logic request_valid, request_good, response_done;
  logic comm_timeout_fault, fault_active, switch_on_disabled, request_accept, busy, dhcp_enable;
  logic [1:0] drive_cmd;
  logic acc;
  logic [31:0] r;
  int fails = 0;
  int checks_done = 0;
  int n;
  localparam int MS_CYCLES = 4;
  logic [15:0] bad_port;
  logic exp_q[$];
  int model_busy = 0;
  always #12.5 clock = ~clock;
  comm_supervision #(.CYCLES_PER_MS(MS_CYCLES)) dut (
    .clock(clock),
    .rst_n(rst_n),
    .window_ms(window_ms),
    .reaction_code(reaction_code),
    .control_source(control_source),
    .addr_option(addr_option),
    .request_valid(request_valid),
    .request_port(request_port),
    .request_good(request_good),
    .response_done(response_done),
    .bus_error(bus_error),
    .drive_at_rest(drive_at_rest),
    .fault_reset(fault_reset),
    .comm_timeout_fault(comm_timeout_fault),
    .fault_active(fault_active),
    .switch_on_disabled(switch_on_disabled),
    .drive_cmd(drive_cmd),
    .request_accept(request_accept),
    .busy(busy),
    .dhcp_enable(dhcp_enable)
  );
  modbus_client cli (
    .clock(clock),
    .request_accept(request_accept),
    .request_valid(request_valid),
    .request_port(request_port),
    .response_done(response_done),
    .request_good(request_good)
  );
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic e, input logic s);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // model of the server's acceptance
  task automatic model_ask(input logic [15:0] p);
    exp_q.push_back(model_busy == 0 && p == `MODBUS_PORT);
    if (model_busy == 0 && p == `MODBUS_PORT)
      model_busy = 1;
  endtask : model_ask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic silent(input int w);
    @(posedge clock);
    window_ms <= w[15:0];
    fault_reset <= 1'b1;
    @(posedge clock);
    fault_reset <= 1'b0;
    #1;
    n = 0;
    while (comm_timeout_fault !== 1'b1 && n < 60)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (w == 0)
      chk("timeout_off", 1'b0, comm_timeout_fault);
    else
      chk("timeout_at", 1'b1, n >= w * MS_CYCLES - 1 && n <= w * MS_CYCLES + 4);
  endtask : silent
  task automatic react(input int c, input int s);
    logic [1:0] ec;
    ec = (s == 0 || c < 2) ? 2'h0 : (c == 2) ? 2'h1 : (c == 4) ? 2'h3 : 2'h2;
    @(posedge clock);
    fault_reset <= 1'b1;
    reaction_code <= c[2:0];
    control_source <= s ? 2'h1 : 2'h2;
    drive_at_rest <= 1'b0;
    @(posedge clock);
    fault_reset <= 1'b0;
    bus_error <= 1'b1;
    @(posedge clock);
    bus_error <= 1'b0;
    #2;
    chk("drive_cmd_lo", ec[0], drive_cmd[0]);
    chk("drive_cmd_hi", ec[1], drive_cmd[1]);
    chk("fault_active", c == 1, fault_active);
    chk("switch_on_disabled", s && c inside {2, 3}, switch_on_disabled);
    if (s && c > 3)
    begin
      @(posedge clock);
      drive_at_rest <= 1'b1;
      repeat (5) @(posedge clock);
      #1;
      chk("rest_fault", 1'b1, fault_active);
    end
  endtask : react
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    end_sim();
  end
  initial
  begin
    r = $urandom(32'h16614121);
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    silent(0);
    silent(3);
    silent(1);
    @(posedge clock);
    window_ms <= 16'h0003;
    fault_reset <= 1'b1;
    @(posedge clock);
    fault_reset <= 1'b0;
    repeat (4)
    begin
      model_ask(`MODBUS_PORT);
      cli.ask(`MODBUS_PORT, acc);
      chk("accept", exp_q.pop_front(), acc);
      model_ask(`MODBUS_PORT);
      cli.ask(`MODBUS_PORT, acc);
      chk("busy_refuse", exp_q.pop_front(), acc);
      model_busy = 0;
      cli.answer(1'b1);
    end
    #1;
    chk("timer_restart", 1'b0, comm_timeout_fault);
    @(posedge clock);
    r = $urandom;
    bad_port = (r[15:0] == `MODBUS_PORT) ? 16'h0007 : r[15:0];
    model_ask(bad_port);
    cli.ask(bad_port, acc);
    chk("port_refuse", exp_q.pop_front(), acc);
    model_ask(`MODBUS_PORT);
    cli.ask(`MODBUS_PORT, acc);
    chk("accept_again", exp_q.pop_front(), acc);
    model_busy = 0;
    cli.answer(1'b0);
    repeat (6) @(posedge clock);
    #1;
    chk("bad_no_restart", 1'b1, comm_timeout_fault);
    repeat (8)
    begin
      @(posedge clock);
      r = $urandom;
      addr_option <= r[0];
      @(posedge clock);
      #1;
      chk("dhcp_enable", r[0], dhcp_enable);
    end
    @(posedge clock);
    window_ms <= 16'h0000;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 6; c++)
        react(c, s);
    end_sim();
  end
endmodule : comm_supervision_tb
